/* rtl/decode_if.sv */
// carrier between the instruction register and the field decoder
`timescale 1ns/100ps
`default_nettype none
interface decode_if;
  import instr_exec_pkg::*;
  logic [INSTR_W-1:0] instr;
  op_type op;
  logic dest;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] literal;
  modport decoder (input instr, output op, output dest, output addr, output literal);
  modport exec (output instr, input op, input dest, input addr, input literal);
endinterface
`default_nettype wire

/* rtl/instr_exec.sv */
// four-phase execute unit with accumulator, file registers and zero flag
// Operation
// RULE_01: move file register copies addressed register
// RULE_02: destination bit zero accumulator, one file
// RULE_03: move file register updates zero flag
// RULE_04: move file: decode, read, write phases
// RULE_05: store accumulator to file, flags kept
// RULE_06: store: decode, read, process, write phases
// RULE_07: load literal into accumulator, flags kept
// RULE_08: or accumulator with file, updates zero
`timescale 1ns/100ps
`default_nettype none
module instr_exec (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [instr_exec_pkg::INSTR_W-1:0] INSTR_WORD,
  input wire logic [instr_exec_pkg::ADDR_W-1:0] FILE_RD_ADDR,
  output var logic [1:0] PHASE,
  output var logic [instr_exec_pkg::DATA_W-1:0] ACCUM,
  output var logic RESULT_NULL_FLAG,
  output var logic [instr_exec_pkg::DATA_W-1:0] FILE_RD_DATA,
  output var logic UNKNOWN_INSTR
);
  import instr_exec_pkg::*;

  // ==========================================================
  // state
  phase_type phase_reg, phase_next;
  logic [INSTR_W-1:0] instr_reg, instr_next;
  logic [DATA_W-1:0] operand_reg, operand_next;
  logic [DATA_W-1:0] result_reg, result_next;
  logic [DATA_W-1:0] accum_reg, accum_next;
  logic flag_reg, flag_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic unknown_reg, unknown_next;
  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic file_we;
  logic [DATA_W-1:0] file_wdata;

  decode_if dec ();

  assign dec.instr = instr_reg;

  instr_field_decode u_decode (
    .dec(dec)
  );

  // ==========================================================
  // phase sequencer
  always_comb begin
    unique case (phase_reg)
      PH_Q1: phase_next = PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================
  // datapath
  always_comb begin
    instr_next = instr_reg;
    operand_next = operand_reg;
    result_next = result_reg;
    accum_next = accum_reg;
    flag_next = flag_reg;
    unknown_next = unknown_reg;
    file_we = 1'b0;
    file_wdata = result_reg;
    rd_data_next = file_mem[FILE_RD_ADDR];
    unique case (phase_reg)
      // word held for the whole cycle, so decode is stable Q2..Q4
      PH_Q1: instr_next = INSTR_WORD; // RULE_04 RULE_06
      PH_Q2: begin
        unknown_next = (dec.op == OP_NONE);
        if (dec.op == OP_LIT) begin
          operand_next = dec.literal; // RULE_07
        end else begin
          operand_next = file_mem[dec.addr]; // RULE_04 RULE_06
        end
      end
      PH_Q3: begin
        unique case (dec.op)
          OP_OR: result_next = operand_reg | accum_reg; // RULE_08
          OP_MOVE: result_next = operand_reg; // RULE_01
          OP_STORE: result_next = accum_reg; // RULE_05 RULE_06
          OP_LIT: result_next = operand_reg; // RULE_07
          OP_NONE: result_next = result_reg;
        endcase
      end
      PH_Q4: begin
        unique case (dec.op)
          OP_OR, OP_MOVE: begin
            if (dec.dest) begin
              file_we = 1'b1; // RULE_02
            end else begin
              accum_next = result_reg; // RULE_02
            end
            flag_next = (result_reg == '0); // RULE_03 RULE_08
          end
          // store and literal leave the zero flag alone
          OP_STORE: file_we = 1'b1; // RULE_05 RULE_06
          OP_LIT: accum_next = result_reg; // RULE_07
          OP_NONE: accum_next = accum_reg;
        endcase
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      instr_reg <= INSTR_RST;
      operand_reg <= '0;
      result_reg <= '0;
      accum_reg <= ACCUM_RST;
      flag_reg <= NULL_FLAG_RST;
      rd_data_reg <= FILE_RST;
      unknown_reg <= 1'b0;
    end else begin
      instr_reg <= instr_next;
      operand_reg <= operand_next;
      result_reg <= result_next;
      accum_reg <= accum_next;
      flag_reg <= flag_next;
      rd_data_reg <= rd_data_next;
      unknown_reg <= unknown_next;
    end
  end

  // ==========================================================
  // file registers
  // reset of the whole array costs area but keeps reads defined
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else if (file_we) begin
      file_mem[dec.addr] <= file_wdata; // RULE_01 RULE_05
    end
  end

  // ==========================================================
  // outputs
  assign PHASE = phase_reg;
  assign ACCUM = accum_reg;
  assign RESULT_NULL_FLAG = flag_reg;
  assign FILE_RD_DATA = rd_data_reg;
  assign UNKNOWN_INSTR = unknown_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_q3_move;
    phase_reg == PH_Q3 && dec.op == OP_MOVE;
  endsequence

  sequence s_q2_store;
    phase_reg == PH_Q2 && dec.op == OP_STORE;
  endsequence

  sequence s_store_tail;
    phase_reg == PH_Q3 ##1 (phase_reg == PH_Q4 && file_we);
  endsequence

  sequence s_move_tail;
    phase_reg == PH_Q3 ##1 phase_reg == PH_Q4 ##1 phase_reg == PH_Q1;
  endsequence

  a_move_to_accum: assert property (s_q3_move and dec.dest == 1'b0 |-> // RULE_01
    ##2 accum_reg == $past(operand_reg, 2))
    else $error("move to accumulator lost the value");

  a_move_keeps_file: assert property (s_q3_move and dec.dest == 1'b0 |-> // RULE_02
    ##2 file_mem[dec.addr] == $past(file_mem[dec.addr], 2))
    else $error("move to accumulator touched the file");

  a_move_to_file: assert property (s_q3_move and dec.dest == 1'b1 |-> // RULE_02
    ##2 (file_mem[dec.addr] == $past(operand_reg, 2) && accum_reg == $past(accum_reg, 2)))
    else $error("move to file wrote the wrong place");

  a_move_zero_flag: assert property (s_q3_move |-> // RULE_03
    ##2 flag_reg == ($past(operand_reg, 2) == 8'h00))
    else $error("move did not set zero flag from value");

  a_move_phases: assert property (phase_reg == PH_Q2 && dec.op == OP_MOVE |-> // RULE_04
    ##1 s_move_tail)
    else $error("move cycle phases out of order");

  a_file_write_q4: assert property (file_we |-> phase_reg == PH_Q4) // RULE_04
    else $error("file write outside fourth phase");

  a_store_value: assert property (phase_reg == PH_Q3 && dec.op == OP_STORE |-> // RULE_05
    ##2 (file_mem[dec.addr] == $past(accum_reg, 2) && flag_reg == $past(flag_reg, 2)))
    else $error("store wrong value or touched flag");

  a_store_phases: assert property (s_q2_store |-> ##1 s_store_tail) // RULE_06
    else $error("store did not write in fourth phase");

  a_load_literal: assert property (phase_reg == PH_Q2 && dec.op == OP_LIT |-> // RULE_07
    ##3 (accum_reg == $past(dec.literal, 3) && flag_reg == $past(flag_reg, 3)))
    else $error("literal load wrong or flag changed");

  a_or_result: assert property (phase_reg == PH_Q3 && dec.op == OP_OR && !dec.dest |-> // RULE_08
    ##2 (accum_reg == ($past(operand_reg, 2) | $past(accum_reg, 2))
    && flag_reg == (accum_reg == 8'h00)))
    else $error("or result or zero flag wrong");

  a_or_to_file: assert property (phase_reg == PH_Q3 && dec.op == OP_OR && dec.dest |-> // RULE_08
    ##2 (file_mem[dec.addr] == ($past(operand_reg, 2) | $past(accum_reg, 2))
    && accum_reg == $past(accum_reg, 2) && flag_reg == (file_mem[dec.addr] == 8'h00)))
    else $error("or to file wrote wrong value or flag");

endmodule
`default_nettype wire

/* rtl/instr_exec_pkg.sv */
// shared constants and types for the four-instruction execute block
package instr_exec_pkg;

  // ==========================================================
  // widths
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;

  // ==========================================================
  // instruction fields
  localparam int OPC6_MSB = 13;
  localparam int OPC6_LSB = 8;
  localparam int OPC7_LSB = 7;
  localparam int OPC4_LSB = 10;
  localparam int DEST_BIT = 7;
  localparam int ADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  localparam logic [5:0] OPC_OR_ACCUM = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [6:0] OPC_STORE_ACCUM = 7'h01;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hC;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic NULL_FLAG_RST = 1'b0;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;
  typedef enum logic [2:0] {OP_NONE, OP_OR, OP_MOVE, OP_STORE, OP_LIT} op_type;

endpackage

/* rtl/instr_field_decode.sv */
// field decoder for the four supported instruction words
`timescale 1ns/100ps
`default_nettype none
module instr_field_decode (
  decode_if.decoder dec
);
  import instr_exec_pkg::*;

  // ==========================================================
  // decode
  always_comb begin
    dec.dest = dec.instr[DEST_BIT];
    dec.addr = dec.instr[ADDR_LSB +: ADDR_W];
    // bits 9:8 of a literal word are ignored
    dec.literal = dec.instr[LIT_LSB +: DATA_W];
    if (dec.instr[OPC6_MSB:OPC6_LSB] == OPC_OR_ACCUM) begin
      dec.op = OP_OR;
    end else if (dec.instr[OPC6_MSB:OPC6_LSB] == OPC_MOVE_FILE) begin
      dec.op = OP_MOVE;
    end else if (dec.instr[OPC6_MSB:OPC7_LSB] == OPC_STORE_ACCUM) begin
      dec.op = OP_STORE;
    end else if (dec.instr[OPC6_MSB:OPC4_LSB] == OPC_LOAD_LIT) begin
      dec.op = OP_LIT;
    end else begin
      dec.op = OP_NONE;
    end
  end

endmodule
`default_nettype wire

/* verif/move_and_or_instruction_exec_tb_top.sv */
// self-checking testbench for the four-instruction execute block
`timescale 1ns/100ps
`default_nettype none
module move_and_or_instruction_exec_tb_top;
  import instr_exec_pkg::*;
  // ==========================================================
  // signals and reference state
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [INSTR_W-1:0] instr_word = INSTR_RST;
  logic [ADDR_W-1:0] file_rd_addr = 7'h00;
  logic [1:0] phase;
  logic [DATA_W-1:0] accum;
  logic result_null_flag;
  logic [DATA_W-1:0] file_rd_data;
  logic unknown_instr;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'h3762;
  logic [DATA_W-1:0] m_accum = ACCUM_RST;
  logic m_flag = NULL_FLAG_RST;
  logic [DATA_W-1:0] m_file [FILE_DEPTH];
  logic [31:0] rnd;

  always #5 core_clk = ~core_clk;

  instr_exec instr_exec_inst (
    .CORE_CLK(core_clk),
    .RESET_N(reset_n),
    .INSTR_WORD(instr_word),
    .FILE_RD_ADDR(file_rd_addr),
    .PHASE(phase),
    .ACCUM(accum),
    .RESULT_NULL_FLAG(result_null_flag),
    .FILE_RD_DATA(file_rd_data),
    .UNKNOWN_INSTR(unknown_instr)
  );

  // ==========================================================
  // checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard: 214 words at 4 cycles each
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================
  // reference decode: 1 or, 2 move, 3 store, 4 load, 0 unknown
  function automatic int op_of(input logic [13:0] w);
    if (w[13:8] == OPC_OR_ACCUM) return 1;
    if (w[13:8] == OPC_MOVE_FILE) return 2;
    if (w[13:7] == OPC_STORE_ACCUM) return 3;
    if (w[13:10] == OPC_LOAD_LIT) return 4;
    return 0;
  endfunction

  // one instruction cycle; entered just after the edge that starts Q1
  task automatic exec(input logic [13:0] w);
    logic [6:0] f;
    logic [7:0] r;
    logic [7:0] old_accum;
    int op;
    f = w[6:0];
    op = op_of(w);
    old_accum = m_accum;
    instr_word = w;
    @(posedge core_clk);
    #1;
    // read port still shows the previous word's target, now written
    check(file_rd_data, m_file[file_rd_addr], "file");
    file_rd_addr = f;
    r = (op == 1) ? (m_accum | m_file[f]) : m_file[f];
    if (op == 1 || op == 2) begin
      m_flag = (r == 8'h00);
      if (w[7]) m_file[f] = r;
      else m_accum = r;
    end
    if (op == 3) m_file[f] = m_accum;
    if (op == 4) m_accum = w[7:0];
    repeat (2) @(posedge core_clk);
    #1;
    check(accum, old_accum, "early write");
    check({6'h00, phase}, 8'h03, "mid phase");
    check({7'h00, unknown_instr}, {7'h00, op == 0}, "unknown");
    @(posedge core_clk);
    #1;
    check(accum, m_accum, "accum");
    check({7'h00, result_null_flag}, {7'h00, m_flag}, "flag");
    check({6'h00, phase}, 8'h00, "phase");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < FILE_DEPTH; i++) m_file[i] = FILE_RST;
    repeat (3) @(posedge core_clk);
    #1;
    check(accum, ACCUM_RST, "reset accum");
    check({7'h00, result_null_flag}, 8'h00, "reset flag");
    check({6'h00, phase}, 8'h00, "reset phase");
    reset_n = 1'b1;
    exec(14'h0000);
    exec(14'h335A);
    exec(14'h00FF);
    exec(14'h087F);
    exec(14'h3000);
    exec(14'h0890);
    exec(14'h3080);
    exec(14'h00FF);
    exec(14'h04FF);
    exec(14'h3000);
    exec(14'h0410);
    exec(14'h08FF);
    exec(14'h00C1);
    exec(14'h0841);
    for (int n = 0; n < 200; n++) begin
      rnd = $random(seed);
      // narrow address range half the time so words share registers
      if (rnd[20]) rnd[6:3] = 4'h0;
      case ($unsigned(rnd[31:24]) % 5)
        0: exec({OPC_OR_ACCUM, rnd[7:0]});
        1: exec({OPC_MOVE_FILE, rnd[7:0]});
        2: exec({OPC_STORE_ACCUM, rnd[6:0]});
        3: exec({OPC_LOAD_LIT, rnd[9:0]});
        default: exec(rnd[13:0]);
      endcase
    end
    // last word's write reaches the read port one edge later
    @(posedge core_clk);
    #1;
    check(file_rd_data, m_file[file_rd_addr], "last file");
    end_sim();
  end
endmodule
`default_nettype wire
